// ===== gtf_pkg.sv
`default_nettype none
package gtf_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_GAIN_B0_DUAL   = 12'h352;
  localparam logic [11:0] IDX_GAIN_B1_DUAL   = 12'h353;
  localparam logic [11:0] IDX_GAIN_A0_SINGLE = 12'h354;
  localparam logic [11:0] IDX_GAIN_A1_SINGLE = 12'h355;
  localparam logic [11:0] IDX_GAIN_B0_SINGLE = 12'h356;
  localparam logic [11:0] IDX_GAIN_B1_SINGLE = 12'h357;
  localparam logic [11:0] IDX_FILTER_CTRL    = 12'h400;
  localparam logic [11:0] IDX_FILTER_STATUS  = 12'h401;

  // Internal slot numbers, also the fuse store index of each gain
  localparam int unsigned NUM_GAIN        = 6;
  localparam logic [2:0]  SLOT_CTRL       = 3'h6;
  localparam logic [2:0]  SLOT_STATUS     = 3'h7;
  localparam logic [3:0]  SLOT_NONE       = 4'hF;

  // Fine gain field
  localparam int unsigned GAIN_LSB        = 0;
  localparam int unsigned GAIN_W          = 5;
  localparam logic [4:0]  GAIN_RESET      = 5'h00;

  // Filter control fields
  localparam int unsigned MODE_LSB        = 0;
  localparam int unsigned MODE_W          = 2;
  localparam int unsigned SCW_LSB         = 2;
  localparam int unsigned SCW_W           = 3;
  localparam int unsigned MERGE_BIT       = 5;
  localparam int unsigned SHARE_BIT       = 6;
  localparam logic [1:0]  MODE_OFF        = 2'h0;
  localparam logic [1:0]  MODE_ON         = 2'h2;
  localparam logic [2:0]  SCW_RESET       = 3'h0;

  // Filter status fields
  localparam int unsigned STAT_ACTIVE_BIT = 0;
  localparam int unsigned STAT_MERGED_BIT = 1;
  localparam int unsigned STAT_LATE_BIT   = 2;
  localparam int unsigned STAT_RSVD_BIT   = 3;

  // Datapath widths and weights
  localparam int unsigned SAMPLE_W        = 8;
  localparam int unsigned COEF_W          = 12;
  localparam int unsigned COEF_EXT_W      = 19;
  localparam int unsigned PROD_W          = 27;
  localparam int unsigned LSB_EXP_BASE    = 16;
  localparam logic [2:0]  CENTRE_SHIFT    = 3'h5;

  // AHB-Lite encodings
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic        HRESP_OKAY      = 1'h0;

  typedef enum logic [1:0] {
    GTF_FS_BYPASS = 2'b01,
    GTF_FS_ACTIVE = 2'b10
  } gtf_fstate_e;

endpackage
`default_nettype wire

// ===== gtf_tap_scale.sv
`timescale 1ns/10ps
`default_nettype none
module gtf_tap_scale (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [7:0]  sample_in,
  input  wire logic        sample_valid,
  input  wire logic [11:0] coef,
  input  wire logic        coef_centre,
  input  wire logic [2:0]  scw,
  input  wire logic        enable,
  output var  logic [7:0]  sample_out,
  output var  logic        out_valid
);

  logic signed [18:0] coef_ext;
  logic signed [18:0] coef_w;
  logic signed [26:0] product;
  logic        [2:0]  shamt;

  assign coef_ext = {{(gtf_pkg::COEF_EXT_W - gtf_pkg::COEF_W){coef[11]}}, coef};
  // Side taps weigh 2^(scw-16), the centre tap a fixed weight
  assign shamt    = coef_centre ? gtf_pkg::CENTRE_SHIFT : scw;
  assign coef_w   = coef_ext <<< shamt;
  assign product  = $signed(sample_in) * coef_w;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_out <= 8'h00;
    end else if (sample_valid) begin
      if (enable) begin
        sample_out <= product[gtf_pkg::LSB_EXP_BASE +: gtf_pkg::SAMPLE_W];
      end else begin
        sample_out <= sample_in;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= sample_valid;
    end
  end

endmodule
`default_nettype wire

// ===== gtf_gain_fir_cfg.sv
`timescale 1ns/10ps
`default_nettype none
module gtf_gain_fir_cfg (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        fuse_valid,
  input  wire logic [2:0]  fuse_index,
  input  wire logic [4:0]  fuse_gain,
  input  wire logic        serial_link_enable,
  output logic [4:0]       fine_gain_b_bank0_dual,
  output logic [4:0]       fine_gain_b_bank1_dual,
  output logic [4:0]       fine_gain_a_bank0_single,
  output logic [4:0]       fine_gain_a_bank1_single,
  output logic [4:0]       fine_gain_b_bank0_single,
  output logic [4:0]       fine_gain_b_bank1_single,
  output logic             coefficient_share_bit,
  output logic             filter_merge_bit,
  output logic [2:0]       side_coefficient_weight,
  output logic [1:0]       filter_mode_field,
  input  wire logic [7:0]  adc_sample_a,
  input  wire logic [7:0]  adc_sample_b,
  input  wire logic        adc_sample_valid,
  input  wire logic [11:0] coef_a,
  input  wire logic [11:0] coef_b,
  input  wire logic        coef_centre,
  output logic [7:0]       eq_sample_a,
  output logic [7:0]       eq_sample_b,
  output logic             eq_valid,
  output var  logic        eq_merged
);

  logic [4:0]  gain_r [0:5];
  logic [4:0]  gain_nxt [0:5];
  logic        share_r;
  logic        share_nxt;
  logic        merge_r;
  logic        merge_nxt;
  logic [2:0]  scw_r;
  logic [2:0]  scw_nxt;
  logic [1:0]  mode_r;
  logic [1:0]  mode_nxt;
  logic        late_r;
  logic        late_nxt;
  logic        dp_valid_r;
  logic        dp_write_r;
  logic [3:0]  dp_slot_r;
  logic        wr_now;
  logic        ap_take;
  logic [3:0]  ap_slot;
  logic [31:0] rd_word;
  logic [7:0]  ctrl_byte;
  logic [7:0]  stat_byte;
  logic [11:0] coef_b_eff;
  logic        out_valid_a;
  logic        out_valid_b;
  gtf_pkg::gtf_fstate_e fstate_r;
  gtf_pkg::gtf_fstate_e fstate_nxt;

  // Word-aligned index decode into an internal slot
  function automatic logic [3:0] slot_of(input logic [31:0] a);
    logic [3:0] s;
    s = gtf_pkg::SLOT_NONE;
    if (a[1:0] == 2'h0 && a[31:14] == 18'h00000) begin
      case (a[13:2])
        gtf_pkg::IDX_GAIN_B0_DUAL:   s = 4'h0;
        gtf_pkg::IDX_GAIN_B1_DUAL:   s = 4'h1;
        gtf_pkg::IDX_GAIN_A0_SINGLE: s = 4'h2;
        gtf_pkg::IDX_GAIN_A1_SINGLE: s = 4'h3;
        gtf_pkg::IDX_GAIN_B0_SINGLE: s = 4'h4;
        gtf_pkg::IDX_GAIN_B1_SINGLE: s = 4'h5;
        gtf_pkg::IDX_FILTER_CTRL:    s = {1'b0, gtf_pkg::SLOT_CTRL};
        gtf_pkg::IDX_FILTER_STATUS:  s = {1'b0, gtf_pkg::SLOT_STATUS};
        default:                     s = gtf_pkg::SLOT_NONE;
      endcase
    end
    return s;
  endfunction

  // Zero-wait slave: every transfer completes in one data phase
  assign hreadyout = 1'b1;
  assign hresp     = gtf_pkg::HRESP_OKAY;
  assign ap_take   = hsel & hready & htrans[1];
  assign ap_slot   = slot_of(haddr);
  assign wr_now    = dp_valid_r & dp_write_r & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_slot_r  <= gtf_pkg::SLOT_NONE;
    end else if (hready) begin
      dp_valid_r <= ap_take;
      dp_write_r <= hwrite;
      dp_slot_r  <= ap_slot;
    end
  end

  // Fuse defaults arrive after reset; a software write in the same cycle wins
  always_comb begin
    for (int i = 0; i < gtf_pkg::NUM_GAIN; i++) begin
      gain_nxt[i] = gain_r[i];
      if (fuse_valid && fuse_index == 3'(i)) begin
        gain_nxt[i] = fuse_gain;
      end
      if (wr_now && dp_slot_r == 4'(i)) begin
        gain_nxt[i] = hwdata[gtf_pkg::GAIN_LSB +: gtf_pkg::GAIN_W];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < gtf_pkg::NUM_GAIN; i++) begin
        gain_r[i] <= gtf_pkg::GAIN_RESET;
      end
    end else begin
      for (int i = 0; i < gtf_pkg::NUM_GAIN; i++) begin
        gain_r[i] <= gain_nxt[i];
      end
    end
  end

  assign fine_gain_b_bank0_dual   = gain_r[0];
  assign fine_gain_b_bank1_dual   = gain_r[1];
  assign fine_gain_a_bank0_single = gain_r[2];
  assign fine_gain_a_bank1_single = gain_r[3];
  assign fine_gain_b_bank0_single = gain_r[4];
  assign fine_gain_b_bank1_single = gain_r[5];

  // Filter control; weight 7 is stored as written, software keeps to 0..6
  always_comb begin
    share_nxt = share_r;
    merge_nxt = merge_r;
    scw_nxt   = scw_r;
    mode_nxt  = mode_r;
    if (wr_now && dp_slot_r == {1'b0, gtf_pkg::SLOT_CTRL}) begin
      share_nxt = hwdata[gtf_pkg::SHARE_BIT];
      merge_nxt = hwdata[gtf_pkg::MERGE_BIT];
      scw_nxt   = hwdata[gtf_pkg::SCW_LSB +: gtf_pkg::SCW_W];
      mode_nxt  = hwdata[gtf_pkg::MODE_LSB +: gtf_pkg::MODE_W];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      share_r <= 1'b0;
      merge_r <= 1'b0;
      scw_r   <= gtf_pkg::SCW_RESET;
      mode_r  <= gtf_pkg::MODE_OFF;
    end else begin
      share_r <= share_nxt;
      merge_r <= merge_nxt;
      scw_r   <= scw_nxt;
      mode_r  <= mode_nxt;
    end
  end

  assign coefficient_share_bit   = share_r;
  assign filter_merge_bit        = merge_r;
  assign side_coefficient_weight = scw_r;
  assign filter_mode_field       = mode_r;

  // Sticky flag for control writes while the link runs; set beats clear
  always_comb begin
    late_nxt = late_r;
    if (wr_now && dp_slot_r == {1'b0, gtf_pkg::SLOT_STATUS} && hwdata[gtf_pkg::STAT_LATE_BIT]) begin
      late_nxt = 1'b0;
    end
    if (wr_now && dp_slot_r == {1'b0, gtf_pkg::SLOT_CTRL} && serial_link_enable) begin
      late_nxt = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      late_r <= 1'b0;
    end else begin
      late_r <= late_nxt;
    end
  end

  // Reserved mode codes leave the filter bypassed
  always_comb begin
    case (mode_r)
      gtf_pkg::MODE_ON: fstate_nxt = gtf_pkg::GTF_FS_ACTIVE;
      default:          fstate_nxt = gtf_pkg::GTF_FS_BYPASS;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fstate_r <= gtf_pkg::GTF_FS_BYPASS;
    end else begin
      fstate_r <= fstate_nxt;
    end
  end

  // Gain, control and late-flag read data built from next values so a write just before is seen; other status bits are registered
  always_comb begin
    ctrl_byte = 8'h00;
    ctrl_byte[gtf_pkg::SHARE_BIT] = share_nxt;
    ctrl_byte[gtf_pkg::MERGE_BIT] = merge_nxt;
    ctrl_byte[gtf_pkg::SCW_LSB +: gtf_pkg::SCW_W] = scw_nxt;
    ctrl_byte[gtf_pkg::MODE_LSB +: gtf_pkg::MODE_W] = mode_nxt;
    stat_byte = 8'h00;
    stat_byte[gtf_pkg::STAT_ACTIVE_BIT] = (fstate_r == gtf_pkg::GTF_FS_ACTIVE);
    stat_byte[gtf_pkg::STAT_MERGED_BIT] = merge_r;
    stat_byte[gtf_pkg::STAT_LATE_BIT]   = late_nxt;
    stat_byte[gtf_pkg::STAT_RSVD_BIT]   = (mode_r != gtf_pkg::MODE_OFF) && (mode_r != gtf_pkg::MODE_ON);
    rd_word = 32'h00000000;
    case (ap_slot)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
        rd_word[gtf_pkg::GAIN_LSB +: gtf_pkg::GAIN_W] = gain_nxt[ap_slot[2:0]];
      end
      {1'b0, gtf_pkg::SLOT_CTRL}: begin
        rd_word[7:0] = ctrl_byte;
      end
      {1'b0, gtf_pkg::SLOT_STATUS}: begin
        rd_word[7:0] = stat_byte;
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ap_take && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // Merged filter runs one coefficient set over both lanes
  assign coef_b_eff = (share_r || merge_r) ? coef_a : coef_b;

  gtf_tap_scale u_lane_a (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .sample_in    (adc_sample_a),
    .sample_valid (adc_sample_valid),
    .coef         (coef_a),
    .coef_centre  (coef_centre),
    .scw          (scw_r),
    .enable       (fstate_r == gtf_pkg::GTF_FS_ACTIVE),
    .sample_out   (eq_sample_a),
    .out_valid    (out_valid_a)
  );

  gtf_tap_scale u_lane_b (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .sample_in    (adc_sample_b),
    .sample_valid (adc_sample_valid),
    .coef         (coef_b_eff),
    .coef_centre  (coef_centre),
    .scw          (scw_r),
    .enable       (fstate_r == gtf_pkg::GTF_FS_ACTIVE),
    .sample_out   (eq_sample_b),
    .out_valid    (out_valid_b)
  );

  assign eq_valid = out_valid_a & out_valid_b;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eq_merged <= 1'b0;
    end else if (adc_sample_valid) begin
      eq_merged <= merge_r;
    end
  end

endmodule
`default_nettype wire

// ===== gtf_gain_fir_cfg_chk.sv
`timescale 1ns/10ps
`default_nettype none
module gtf_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        fuse_valid,
  input wire logic [2:0]  fuse_index,
  input wire logic [4:0]  fuse_gain,
  input wire logic [4:0]  fine_gain_b_bank0_dual,
  input wire logic        coefficient_share_bit,
  input wire logic        filter_merge_bit,
  input wire logic [2:0]  side_coefficient_weight,
  input wire logic [1:0]  filter_mode_field,
  input wire logic [7:0]  adc_sample_a,
  input wire logic [7:0]  adc_sample_b,
  input wire logic        adc_sample_valid,
  input wire logic [11:0] coef_a,
  input wire logic [11:0] coef_b,
  input wire logic        coef_centre,
  input wire logic [7:0]  eq_sample_a,
  input wire logic [7:0]  eq_sample_b,
  input wire logic        eq_valid,
  input wire logic        eq_merged
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic        tk = hsel && hready && htrans[1];
  wire logic        on = filter_mode_field == gtf_pkg::MODE_ON;
  wire logic [2:0]  sh = coef_centre ? 3'h5 : side_coefficient_weight;
  wire logic [11:0] cb = (coefficient_share_bit || filter_merge_bit) ? coef_a : coef_b;
  function automatic logic [7:0] scl(input logic [7:0] s, input logic [11:0] c, input logic [2:0] k);
    logic signed [26:0] p;
    p = $signed(s) * $signed(c);
    p = p <<< k;
    return p[23:16];
  endfunction
  AST_GAIN_WR: assert property (tk && hwrite && haddr == 32'hD48 |=> ##1 fine_gain_b_bank0_dual == $past(hwdata[4:0]))
    else $error("gain write not applied");
  AST_FUSE: assert property (fuse_valid && fuse_index == 3'h0 |=> fine_gain_b_bank0_dual == $past(fuse_gain))
    else $error("fuse default not loaded");
  AST_RD_RSVD: assert property (tk && !hwrite && haddr[13:2] inside {[12'h352:12'h357]} |=> hrdata[31:5] == 27'h0)
    else $error("reserved gain bits read nonzero");
  AST_CTRL_WR: assert property (tk && hwrite && haddr == 32'h1000 |=> ##1
    {coefficient_share_bit, filter_merge_bit, side_coefficient_weight, filter_mode_field} == $past(hwdata[6:0]))
    else $error("control fields not applied");
  AST_BYPASS: assert property (adc_sample_valid && !on && $stable(filter_mode_field) |=>
    eq_sample_a == $past(adc_sample_a) && eq_sample_b == $past(adc_sample_b)) else $error("bypass altered sample");
  AST_SCALE_A: assert property (adc_sample_valid && on && $stable(filter_mode_field) |=>
    eq_sample_a == $past(scl(adc_sample_a, coef_a, sh))) else $error("lane a scaling wrong");
  AST_LANE_B: assert property (adc_sample_valid && on && $stable({coefficient_share_bit, filter_merge_bit,
    filter_mode_field}) |=> eq_sample_b == $past(scl(adc_sample_b, cb, sh))) else $error("lane b coefficient wrong");
  AST_VALID: assert property (1'b1 |=> eq_valid == $past(adc_sample_valid) &&
    (!eq_valid || eq_merged == $past(filter_merge_bit))) else $error("output valid or merge tag wrong");
endmodule
bind gtf_gain_fir_cfg gtf_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .fuse_valid, .fuse_index, .fuse_gain, .fine_gain_b_bank0_dual, .coefficient_share_bit,
  .filter_merge_bit, .side_coefficient_weight, .filter_mode_field, .adc_sample_a, .adc_sample_b,
  .adc_sample_valid, .coef_a, .coef_b, .coef_centre, .eq_sample_a, .eq_sample_b, .eq_valid, .eq_merged);
`default_nettype wire

// ===== gtf_gain_fir_cfg_tb.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {logic [11:0] i; logic [31:0] w; logic [31:0] r;} gtf_row_s;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, fuse_valid, serial_link_enable;
  logic        coefficient_share_bit, filter_merge_bit, adc_sample_valid, coef_centre, eq_valid, eq_merged;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, filter_mode_field;
  logic [2:0]  hsize, fuse_index, side_coefficient_weight;
  logic [4:0]  fuse_gain, fine_gain_b_bank0_dual, fine_gain_b_bank1_dual, fine_gain_a_bank0_single;
  logic [4:0]  fine_gain_a_bank1_single, fine_gain_b_bank0_single, fine_gain_b_bank1_single;
  logic [7:0]  adc_sample_a, adc_sample_b, eq_sample_a, eq_sample_b;
  logic [11:0] coef_a, coef_b;
  int          fails = 0;
  int          tests_run = 0;
  // Unmapped index last: writes there must leave every port alone
  gtf_row_s    rows [8] = '{'{12'h352, 32'hFFFFFFFF, 32'h1F}, '{12'h353, 32'h15, 32'h15},
    '{12'h354, 32'hFFFFFFEA, 32'h0A}, '{12'h355, 32'h11, 32'h11}, '{12'h356, 32'h1E, 32'h1E},
    '{12'h357, 32'h03, 32'h03}, '{12'h400, 32'hFFFFFFDA, 32'h5A}, '{12'h358, 32'h1F, 32'h00}};
  wire logic [36:0] pv = {coefficient_share_bit, filter_merge_bit, side_coefficient_weight, filter_mode_field,
    fine_gain_b_bank1_single, fine_gain_b_bank0_single, fine_gain_a_bank1_single, fine_gain_a_bank0_single,
    fine_gain_b_bank1_dual, fine_gain_b_bank0_dual};
  gtf_gain_fir_cfg u_gtf_gain_fir_cfg (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .fuse_valid, .fuse_index, .fuse_gain, .serial_link_enable,
    .fine_gain_b_bank0_dual, .fine_gain_b_bank1_dual, .fine_gain_a_bank0_single, .fine_gain_a_bank1_single,
    .fine_gain_b_bank0_single, .fine_gain_b_bank1_single, .coefficient_share_bit, .filter_merge_bit,
    .side_coefficient_weight, .filter_mode_field, .adc_sample_a, .adc_sample_b, .adc_sample_valid, .coef_a,
    .coef_b, .coef_centre, .eq_sample_a, .eq_sample_b, .eq_valid, .eq_merged);
  function automatic logic [31:0] port(input logic [11:0] i);
    if (i == 12'h400) return {25'h0, pv[36:30]};
    if (i < 12'h352 || i > 12'h357) return 32'h0;
    return {27'h0, pv[5*(i-12'h352)+:5]};
  endfunction
  function automatic logic [7:0] scl(input logic [7:0] s, input logic [11:0] c, input logic [2:0] k);
    logic signed [26:0] p;
    p = $signed(s) * $signed(c);
    p = p <<< k;
    return p[23:16];
  endfunction
  task automatic complete_run();
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wt();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      fails++;
      complete_run();
    end
  endtask
  // Entered just after an edge, so transfers run back to back
  task automatic xfer(input logic w, input logic [11:0] i, input logic [31:0] d);
    htrans <= gtf_pkg::HTRANS_NONSEQ;
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {18'h0, i, 2'b00};
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, gtf_pkg::HRESP_OKAY});
  endtask
  // Extra cycle lets the mode state register follow the write
  task automatic cfg(input logic [6:0] v);
    xfer(1'b1, 12'h400, {25'h0, v});
    @(posedge hclk);
  endtask
  task automatic run(input logic on, input logic cen, input logic [2:0] s, input logic sa, input logic m);
    logic [7:0] a;
    logic [7:0] b;
    a = 8'h9C + 8'(s);
    b = 8'h41 - 8'(s);
    adc_sample_a <= a;
    adc_sample_b <= b;
    coef_a <= 12'h801;
    coef_b <= 12'h7FF;
    coef_centre <= cen;
    adc_sample_valid <= 1'b1;
    @(posedge hclk);
    adc_sample_valid <= 1'b0;
    #1;
    chk({eq_valid, eq_merged, eq_sample_a, eq_sample_b}, {1'b1, m, on ? scl(a, 12'h801, cen ? 3'h5 : s) : a,
      on ? scl(b, sa ? 12'h801 : 12'h7FF, cen ? 3'h5 : s) : b});
    @(posedge hclk);
  endtask
  task automatic rst_chk();
    for (int k = 0; k < 8; k++) begin
      xfer(1'b0, rows[k].i, 32'h0);
      chk(rd, 32'h0);
      chk(port(rows[k].i), 32'h0);
    end
  endtask
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, fuse_valid, adc_sample_valid, coef_centre, serial_link_enable} = '0;
    {haddr, hwdata, htrans, fuse_index, fuse_gain, adc_sample_a, adc_sample_b, coef_a, coef_b} = '0;
    hsize = 3'h2;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rst_chk();
    // Indices 6 and 7 carry loads that must land nowhere
    for (int k = 0; k < 8; k++) begin
      fuse_valid <= 1'b1;
      fuse_index <= 3'(k);
      fuse_gain <= 5'h11 + 5'(k);
      @(posedge hclk);
    end
    fuse_valid <= 1'b0;
    @(posedge hclk);
    for (int k = 0; k < 6; k++) chk(port(12'h352 + 12'(k)), 32'h11 + 32'(k));
    foreach (rows[k]) begin
      xfer(1'b1, rows[k].i, rows[k].w);
      xfer(1'b0, rows[k].i, 32'h0);
      chk(rd, rows[k].r);
      chk(port(rows[k].i), rows[k].r);
    end
    // The unmapped write came last, so every mapped register must still hold its row value
    for (int k = 0; k < 7; k++) chk(port(rows[k].i), rows[k].r);
    for (int k = 0; k < 4; k++) begin
      if (k != 2) begin
        cfg({2'b00, 3'h3, 2'(k)});
        run(1'b0, 1'b0, 3'h3, 1'b0, 1'b0);
      end
    end
    for (int s = 0; s < 7; s++) begin
      cfg({2'b00, 3'(s), gtf_pkg::MODE_ON});
      run(1'b1, 1'b0, 3'(s), 1'b0, 1'b0);
    end
    cfg({2'b00, 3'h1, gtf_pkg::MODE_ON});
    run(1'b1, 1'b1, 3'h1, 1'b0, 1'b0);
    cfg({2'b10, 3'h2, gtf_pkg::MODE_ON});
    run(1'b1, 1'b0, 3'h2, 1'b1, 1'b0);
    cfg({2'b01, 3'h2, gtf_pkg::MODE_ON});
    run(1'b1, 1'b0, 3'h2, 1'b1, 1'b1);
    xfer(1'b0, 12'h401, 32'h0);
    chk(rd, 32'h3);
    // Control written with the link running: sticky flag, reserved mode seen
    serial_link_enable <= 1'b1;
    cfg({2'b01, 3'h2, 2'h3});
    xfer(1'b0, 12'h401, 32'h0);
    chk(rd, 32'hE);
    serial_link_enable <= 1'b0;
    xfer(1'b1, 12'h401, 32'h4);
    xfer(1'b0, 12'h401, 32'h0);
    chk(rd, 32'hA);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rst_chk();
    xfer(1'b0, 12'h401, 32'h0);
    chk(rd, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
